// >>> hdl/cpp_port.sv
// control pin port with slave status: wishbone registers on one side, pins on the other
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/10ps
module cpp_port
    import cpp_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    input  wire logic       porN,        // low only for power-on reset
    input  wire logic       wb_cyc_i,
    input  wire logic       wb_stb_i,
    input  wire logic       wb_we_i,
    input  wire logic [7:0] wb_adr_i,
    input  wire logic [7:0] wb_dat_i,
    input  wire logic       wb_sel_i,
    input  wire logic [1:0] wb_op_i,     // write, bit set, bit clear
    input  wire logic [2:0] wb_bit_i,    // bit picked by set/clear
    output logic [7:0]      wb_dat_o,
    output logic            wb_ack_o,
    output logic            wb_err_o,
    cpp_link_if.device      link
);
    logic [7:0] dir_q;            // direction, mode and status flags
    logic [7:0] dir_d;
    logic [2:0] lat_q;            // pin output latch
    logic [2:0] lat_d;
    logic [7:0] out_q;            // slave data output latch
    logic [7:0] out_d;
    logic [7:0] in_q;             // slave data input latch
    logic [7:0] in_d;
    logic       ack_q;
    logic       ack_d;
    logic       err_q;
    logic       err_d;
    logic [7:0] rdat_q;
    logic [7:0] rdat_d;
    logic [2:0] pS1_q;            // pin synchroniser, first stage
    logic [2:0] pS2_q;            // pin synchroniser, second stage
    logic [2:0] pPrev_q;          // second stage one cycle late, for edges
    logic [7:0] bS1_q;            // data bus synchroniser
    logic [7:0] bS2_q;
    logic [7:0] bPrev_q;          // bus aligned with pPrev_q

    logic       slave;
    logic       rdAct;
    logic       wrAct;
    logic       rdPrev;
    logic       wrPrev;
    logic       req;
    logic       sdWr;             // software write of the slave data port
    logic [7:0] cur;
    logic [7:0] nv;

    // pins and bus arrive from outside the clock domain
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            pS1_q   <= 3'b111;
            pS2_q   <= 3'b111;
            pPrev_q <= 3'b111;
            bS1_q   <= 8'h00;
            bS2_q   <= 8'h00;
            bPrev_q <= 8'h00;
        end else begin
            pS1_q   <= link.pinIn;
            pS2_q   <= pS1_q;
            pPrev_q <= pS2_q;
            bS1_q   <= link.busIn;
            bS2_q   <= bS1_q;
            bPrev_q <= bS2_q;
        end
    end

    // read-modify-write helper
    // the read half sees pin levels, so a set or clear on one bit copies
    // whatever an input pin shows into its latch; switching that pin to
    // output later drives the copied level, not an older latch value
    function automatic logic [7:0] cpp_apply(input logic [7:0] v, input logic [1:0] op,
                                             input logic [2:0] b, input logic [7:0] d);
        logic [7:0] r;
        r = v;
        case (op)
            CPP_OP_BSET: r[b] = 1'b1;
            CPP_OP_BCLR: r[b] = 1'b0;
            default:     r = d;
        endcase
        return r;
    endfunction : cpp_apply

    assign slave  = dir_q[CPP_BIT_SLAVE];
    assign rdAct  = !pS2_q[CPP_PIN_CS] && !pS2_q[CPP_PIN_RD];
    assign wrAct  = !pS2_q[CPP_PIN_CS] && !pS2_q[CPP_PIN_WR];
    assign rdPrev = !pPrev_q[CPP_PIN_CS] && !pPrev_q[CPP_PIN_RD];
    assign wrPrev = !pPrev_q[CPP_PIN_CS] && !pPrev_q[CPP_PIN_WR];
    assign req    = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
    assign sdWr   = req && wb_we_i && wb_sel_i && (wb_adr_i == CPP_ADDR_SDATA);

    // current read value of the addressed register; pins read, not latch
    // pin levels lag the pins by the two sync stages
    always_comb begin
        case (wb_adr_i)
            CPP_ADDR_DATA:  cur = {5'b0_0000, pS2_q};
            CPP_ADDR_DIR:   cur = {dir_q[7:4], 1'b0, dir_q[2:0]};
            CPP_ADDR_SDATA: cur = in_q;
            default:        cur = 8'h00;
        endcase
        nv = cpp_apply(cur, wb_op_i, wb_bit_i, wb_dat_i);
    end

    // register, flag and bus response next state
    // every access answers after exactly one cycle, err for an unmapped address
    always_comb begin
        dir_d  = dir_q;
        lat_d  = lat_q;
        out_d  = out_q;
        in_d   = in_q;
        ack_d  = 1'b0;
        err_d  = 1'b0;
        rdat_d = rdat_q;
        if (req) begin
            ack_d  = (wb_adr_i == CPP_ADDR_DATA) || (wb_adr_i == CPP_ADDR_DIR) || (wb_adr_i == CPP_ADDR_SDATA);
            err_d  = !ack_d;
            rdat_d = cur;
            if (wb_we_i && wb_sel_i) begin
                case (wb_adr_i)
                    CPP_ADDR_DATA: lat_d = nv[2:0];
                    CPP_ADDR_DIR: begin
                        // full flags are hardware-owned, the write data cannot set them; a write clearing the slave bit clears both below
                        dir_d = (dir_q & ~CPP_DIR_WMASK) | (nv & CPP_DIR_WMASK);
                    end
                    CPP_ADDR_SDATA: begin
                        out_d = nv;
                        dir_d[CPP_BIT_OBFULL] = slave;
                    end
                    default: ;
                endcase
            end else if (!wb_we_i && wb_adr_i == CPP_ADDR_SDATA) begin
                dir_d[CPP_BIT_IBFULL] = 1'b0;
            end
        end
        // external side: detect first low of select with read strobe, and the rise that ends a write
        // events are seen two to three cycles after the pins move
        if (slave) begin
            // a same-cycle software load means fresh data is waiting, so its set wins
            if (rdAct && !rdPrev && !sdWr) begin
                dir_d[CPP_BIT_OBFULL] = 1'b0;
            end
            // write completes when either strobe or select rises
            if (wrPrev && !wrAct) begin
                // take the bus as it stood in the last strobe-low sample; by the
                // time the rise shows up the master may already have let go
                in_d = bPrev_q;
                if (dir_q[CPP_BIT_IBFULL]) begin
                    dir_d[CPP_BIT_OVF] = 1'b1;
                end
                dir_d[CPP_BIT_IBFULL] = 1'b1;
            end
        end
        if (!dir_d[CPP_BIT_SLAVE]) begin
            dir_d[CPP_BIT_IBFULL] = 1'b0;
            dir_d[CPP_BIT_OBFULL] = 1'b0;
        end
        dir_d[3] = 1'b0;
    end

    // direction and status reset on every reset
    // status flags must never survive a reset, unlike the pin latch below
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            dir_q  <= CPP_DIR_RESET;
            out_q  <= 8'h00;
            in_q   <= 8'h00;
            ack_q  <= 1'b0;
            err_q  <= 1'b0;
            rdat_q <= 8'h00;
        end else begin
            dir_q  <= dir_d;
            out_q  <= out_d;
            in_q   <= in_d;
            ack_q  <= ack_d;
            err_q  <= err_d;
            rdat_q <= rdat_d;
        end
    end

    // pin latch kept across ordinary resets; power-on clears it to a known value
    // after power-on the pins are inputs anyway, so the cleared value is harmless
    always_ff @(posedge clk_sys or negedge porN) begin
        if (!porN) begin
            lat_q <= 3'b000;
        end else begin
            lat_q <= lat_d;
        end
    end

    // pin drive: output when direction bit is 0, never in slave mode
    // in slave mode the master owns the strobes, so the direction bits are overridden
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            link.devOe[i] = dir_q[i] | slave;
        end
        link.devOut    = lat_q;
        link.devBusOut = out_q;
        link.devBusOe  = !(slave && rdAct);
    end

    assign wb_dat_o = rdat_q;
    assign wb_ack_o = ack_q;
    assign wb_err_o = err_q;
endmodule : cpp_port

// >>> hdl/cpp_pkg.sv
// package of constants and types for the control pin port and its slave status
package cpp_pkg;
    localparam logic [7:0] CPP_ADDR_DATA  = 8'h09;   // control_pin_data
    localparam logic [7:0] CPP_ADDR_DIR   = 8'h89;   // pin_direction_and_slave_status
    localparam logic [7:0] CPP_ADDR_SDATA = 8'h08;   // slave_data_port
    localparam logic [7:0] CPP_DIR_RESET  = 8'h07;
    localparam int CPP_BIT_IBFULL = 7;
    localparam int CPP_BIT_OBFULL = 6;
    localparam int CPP_BIT_OVF    = 5;
    localparam int CPP_BIT_SLAVE  = 4;
    localparam int CPP_PIN_RD     = 0;
    localparam int CPP_PIN_WR     = 1;
    localparam int CPP_PIN_CS     = 2;
    localparam logic [7:0] CPP_DIR_WMASK = 8'h37;    // bits software may write
    // processor-side operations
    typedef enum logic [1:0] {CPP_OP_WRITE, CPP_OP_BSET, CPP_OP_BCLR} cpp_op_e;
    typedef enum {CPP_H_IDLE, CPP_H_SETUP, CPP_H_STROBE, CPP_H_DONE} cpp_hstate_e;
    localparam logic [3:0] CPP_HOST_HOLD = 4'h4;     // strobe low for this many cycles
endpackage : cpp_pkg

// >>> hdl/cpp_link_if.sv
// interface joining the control pin port to the external bus master
`timescale 1ns/10ps
interface cpp_link_if;
    logic [2:0] pinIn;       // level seen on the three pins
    logic [2:0] devOut;      // device pin drive values
    logic [2:0] devOe;       // device enables, low = driving
    logic [2:0] hostOut;     // master drive: rd, wr, cs (active low)
    logic [2:0] hostOe;      // master enables, low = driving
    logic [7:0] busIn;       // data bus level
    logic [7:0] devBusOut;
    logic       devBusOe;    // low = device drives data bus
    logic [7:0] hostBusOut;
    logic       hostBusOe;
    // wire resolution; undriven pins pull high
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pinIn[i] = !devOe[i] ? devOut[i] : (!hostOe[i] ? hostOut[i] : 1'b1);
        end
        busIn = !devBusOe ? devBusOut : (!hostBusOe ? hostBusOut : 8'hff);
    end
    modport device (input pinIn, busIn, output devOut, devOe, devBusOut, devBusOe);
    modport host   (input pinIn, busIn, output hostOut, hostOe, hostBusOut, hostBusOe);
endinterface : cpp_link_if

// >>> hdl/cpp_host.sv
// external bus master end: drives the three strobes and the data bus
`timescale 1ns/10ps
module cpp_host
    import cpp_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    cpp_link_if.host        link,
    input  wire logic       reqValid,
    input  wire logic       reqWrite,
    input  wire logic [7:0] reqData,
    output logic            reqReady,
    output logic            rspValid,
    output logic [7:0]      rspData
);
    cpp_hstate_e state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic       wr_q, wr_d;
    logic [7:0] dat_q, dat_d;
    logic [7:0] rsp_q, rsp_d;
    logic       rv_q, rv_d;
    logic [7:0] busS1_q, busS2_q;

    // bus data crosses from the pins, two flops first
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            busS1_q <= 8'h00;
            busS2_q <= 8'h00;
        end else begin
            busS1_q <= link.busIn;
            busS2_q <= busS1_q;
        end
    end

    // sequence: select, strobe low for a hold, release
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        wr_d    = wr_q;
        dat_d   = dat_q;
        rsp_d   = rsp_q;
        rv_d    = 1'b0;
        case (state_q)
            CPP_H_IDLE: if (reqValid) begin
                wr_d    = reqWrite;
                dat_d   = reqData;
                state_d = CPP_H_SETUP;
            end
            CPP_H_SETUP: begin
                cnt_d   = CPP_HOST_HOLD;
                state_d = CPP_H_STROBE;
            end
            CPP_H_STROBE: begin
                cnt_d = cnt_q - 4'h1;
                if (cnt_q == 4'h1) begin
                    state_d = CPP_H_DONE;
                end
            end
            CPP_H_DONE: begin
                // the device drives two cycles into the strobe and our own sync adds two
                // more, so the byte only shows up here
                rsp_d   = busS2_q;
                rv_d    = !wr_q;
                state_d = CPP_H_IDLE;
            end
            default: state_d = CPP_H_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_q <= CPP_H_IDLE;
            cnt_q   <= 4'h0;
            wr_q    <= 1'b0;
            dat_q   <= 8'h00;
            rsp_q   <= 8'h00;
            rv_q    <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            wr_q    <= wr_d;
            dat_q   <= dat_d;
            rsp_q   <= rsp_d;
            rv_q    <= rv_d;
        end
    end

    // strobes are active low; select held over setup and strobe
    always_comb begin
        link.hostOe              = 3'b000;
        link.hostOut[CPP_PIN_CS] = !(state_q == CPP_H_SETUP || state_q == CPP_H_STROBE);
        link.hostOut[CPP_PIN_RD] = !(state_q == CPP_H_STROBE && !wr_q);
        link.hostOut[CPP_PIN_WR] = !(state_q == CPP_H_STROBE && wr_q);
        link.hostBusOut          = dat_q;
        link.hostBusOe           = !((state_q == CPP_H_SETUP || state_q == CPP_H_STROBE) && wr_q);
    end

    assign reqReady = (state_q == CPP_H_IDLE);
    assign rspValid = rv_q;
    assign rspData  = rsp_q;
endmodule : cpp_host

// >>> verif/cpp_link_asserts.sv
// checker on the pin link between the port and the bus master
`timescale 1ns/10ps
module cpp_link_asserts (
    input wire logic       clk_sys,
    input wire logic       nrst,
    input wire logic [2:0] pinIn,
    input wire logic [2:0] hostOut,
    input wire logic       hostBusOe,
    input wire logic       devBusOe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // master strobes never overlap; each is qualified by select
    property p_excl;
        hostOut[0] || hostOut[1];
    endproperty
    a_excl: assert property (p_excl) else $error("read and write strobes low together");
    property p_csq;
        !(hostOut[0] && hostOut[1]) |-> !hostOut[2];
    endproperty
    a_csq: assert property (p_csq) else $error("strobe without select");
    // strobe width is fixed so the two sync flops always see it
    property p_rdw;
        $fell(hostOut[0]) |-> !hostOut[0] [*4] ##1 hostOut[0];
    endproperty
    a_rdw: assert property (p_rdw) else $error("read strobe width wrong");
    property p_wrw;
        $fell(hostOut[1]) |-> !hostOut[1] [*4] ##1 hostOut[1];
    endproperty
    a_wrw: assert property (p_wrw) else $error("write strobe width wrong");
    property p_wrd;
        !hostOut[1] |-> !hostBusOe && devBusOe;
    endproperty
    a_wrd: assert property (p_wrd) else $error("bus not held by master in write");
    // device answers only to a read; a quiet read line releases the bus
    property p_idle;
        pinIn[0] [*5] |-> devBusOe;
    endproperty
    a_idle: assert property (p_idle) else $error("device drives bus without read");
    property p_desel;
        pinIn[2] [*5] |-> devBusOe;
    endproperty
    a_desel: assert property (p_desel) else $error("device drives bus while deselected");
    property p_rel;
        $rose(pinIn[0]) |-> ##[1:5] devBusOe;
    endproperty
    a_rel: assert property (p_rel) else $error("bus not released after read");
    property p_gap;
        $rose(hostOut[2]) |-> hostOut[2] [*2];
    endproperty
    a_gap: assert property (p_gap) else $error("select gap too short");
endmodule : cpp_link_asserts

// >>> verif/testbench.sv
// self-checking bench: port and bus master joined by the pin link
`timescale 1ns/10ps
`define CHK(n, e, g) begin samplesChecked++; if ((g) !== (e)) begin failCount++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module testbench;
    import cpp_pkg::*;
    logic       clk_sys = 1'b0;
    logic       nrst = 1'b1;
    logic       porN = 1'b1;
    logic       cyc = 1'b0;
    logic       we = 1'b0;
    logic       sel = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [7:0] wdat = 8'h00;
    logic [1:0] op = 2'h0;
    logic [2:0] bsel = 3'h0;
    logic [7:0] rdat;
    logic       ack;
    logic       err;
    logic       reqValid = 1'b0;
    logic       reqWrite = 1'b0;
    logic [7:0] reqData = 8'h00;
    logic       reqReady;
    logic       rspValid;
    logic [7:0] rspData;
    logic [7:0] rv;
    logic       ev;
    logic [7:0] hv;
    int         failCount = 0;
    int         samplesChecked = 0;
    always #10 clk_sys = ~clk_sys;
    cpp_link_if link ();
    cpp_port u_cpp_port (.clk_sys(clk_sys), .nrst(nrst), .porN(porN), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_op_i(op), .wb_bit_i(bsel),
        .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err), .link(link));
    cpp_host u_cpp_host (.clk_sys(clk_sys), .nrst(nrst), .link(link), .reqValid(reqValid),
        .reqWrite(reqWrite), .reqData(reqData), .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData));
    cpp_link_asserts u_asserts (.clk_sys(clk_sys), .nrst(nrst), .pinIn(link.pinIn), .hostOut(link.hostOut),
        .hostBusOe(link.hostBusOe), .devBusOe(link.devBusOe));
    // one classic cycle, held until ack or err; the idle cycle follows
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [1:0] o,
                      input logic [2:0] b, input logic s);
        int n;
        @(posedge clk_sys);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        op <= o;
        bsel <= b;
        sel <= s;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (ack !== 1'b1 && err !== 1'b1 && n < 40);
        rv = rdat;
        ev = err;
        cyc <= 1'b0;
        if (n >= 40) failCount++;
    endtask : wb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wb(1'b1, a, d, CPP_OP_WRITE, 3'h0, 1'b1);
    endtask : wr
    // pins pass two sync flops, so let them settle before reading
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        repeat (3) @(posedge clk_sys);
        wb(1'b0, a, 8'h00, CPP_OP_WRITE, 3'h0, 1'b1);
        `CHK("read", x, rv)
    endtask : rd
    // one master transfer; writes get a fixed span for the flags to land
    task automatic hx(input logic w, input logic [7:0] d);
        int n;
        @(posedge clk_sys);
        reqValid <= 1'b1;
        reqWrite <= w;
        reqData <= d;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (reqReady !== 1'b1 && n < 40);
        reqValid <= 1'b0;
        if (n >= 40) failCount++;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (!(!w && rspValid === 1'b1) && n < 16);
        hv = rspData;
        if (!w && n >= 16) failCount++;
    endtask : hx
    task automatic tReset;
        rd(CPP_ADDR_DIR, 8'h07);
        rd(CPP_ADDR_DATA, 8'h07);
        wb(1'b1, 8'h55, 8'h00, CPP_OP_WRITE, 3'h0, 1'b1);
        `CHK("err", 1'b1, ev)
        wb(1'b1, CPP_ADDR_DIR, 8'h00, CPP_OP_WRITE, 3'h0, 1'b0);
        rd(CPP_ADDR_DIR, 8'h07);
        wr(CPP_ADDR_DIR, 8'hff);
        rd(CPP_ADDR_DIR, 8'h37);
        $display("reset and access test done");
    endtask : tReset
    task automatic tGpio;
        wr(CPP_ADDR_DIR, 8'h06);
        wr(CPP_ADDR_DATA, 8'h00);
        rd(CPP_ADDR_DATA, 8'h06);
        `CHK("oe", 3'b110, link.devOe)
        wb(1'b1, CPP_ADDR_DATA, 8'h00, CPP_OP_BCLR, 3'h1, 1'b1);
        wr(CPP_ADDR_DIR, 8'h00);
        rd(CPP_ADDR_DATA, 8'h04);
        wb(1'b1, CPP_ADDR_DATA, 8'h00, CPP_OP_BSET, 3'h0, 1'b1);
        rd(CPP_ADDR_DATA, 8'h05);
        `CHK("drv", 3'b101, link.devOut)
        @(posedge clk_sys);
        nrst <= 1'b0;
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        rd(CPP_ADDR_DIR, 8'h07);
        wr(CPP_ADDR_DIR, 8'h00);
        rd(CPP_ADDR_DATA, 8'h05);
        $display("pin port test done");
    endtask : tGpio
    task automatic tSlave;
        wr(CPP_ADDR_DIR, 8'h17);
        wr(CPP_ADDR_SDATA, 8'h5a);
        rd(CPP_ADDR_DIR, 8'h57);
        hx(1'b0, 8'h00);
        `CHK("rsp", 8'h5a, hv)
        rd(CPP_ADDR_DIR, 8'h17);
        hx(1'b1, 8'ha5);
        rd(CPP_ADDR_DIR, 8'h97);
        hx(1'b1, 8'h3c);
        rd(CPP_ADDR_DIR, 8'hb7);
        rd(CPP_ADDR_SDATA, 8'h3c);
        rd(CPP_ADDR_DIR, 8'h37);
        wr(CPP_ADDR_SDATA, 8'h11);
        wr(CPP_ADDR_DIR, 8'h27);
        rd(CPP_ADDR_DIR, 8'h27);
        wr(CPP_ADDR_DIR, 8'hc7);
        rd(CPP_ADDR_DIR, 8'h07);
        hx(1'b1, 8'h66);
        rd(CPP_ADDR_DIR, 8'h07);
        $display("slave link test done");
    endtask : tSlave
    task automatic giveVerdict;
        $display("checks %0d, mismatches %0d", samplesChecked, failCount);
        if (failCount == 0 && samplesChecked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : giveVerdict
    // main sequence after a 16 cycle reset
    initial begin
        // start high and fall at time zero so the asynchronous resets see an edge
        nrst <= 1'b0;
        porN <= 1'b0;
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        porN <= 1'b1;
        tReset();
        tGpio();
        tSlave();
        giveVerdict();
    end
    // watchdog, well beyond the few hundred cycles the tests need
    initial begin
        repeat (4000) @(posedge clk_sys);
        failCount++;
        giveVerdict();
    end
endmodule : testbench
